// ---- watchdog_timer_control.sv ----
// watchdog control/status register with wishbone access and time-out actions
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "wdt_cfg.svh"
module watchdog_timer_control
   import wdt_pkg::*;
#(
   parameter int CW = 21
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic osc_clk_i,
   input wire logic always_on_fuse_i,
   input wire logic reset_cause_flag_i,
   input wire logic global_irq_enable_i,
   input wire logic vector_taken_i,
   input wire logic restart_i,
   output logic irq_o,
   output logic sys_reset_o
);
   logic osc_s;
   logic osc_prev_q;
   logic tick;
   logic fuse_s;
   logic cause_s;
   logic expire;
   logic flag_q;
   logic flag_d;
   logic irqen_q;
   logic irqen_d;
   logic rsten_q;
   logic rsten_d;
   logic unlock_q;
   logic unlock_d;
   logic [2:0] ulcnt_q;
   logic [2:0] ulcnt_d;
   logic [3:0] sel_q;
   logic [3:0] sel_d;
   logic rst_q;
   logic rst_d;
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic wr_ctrl;
   logic rd;
   logic [7:0] wv;
   logic [7:0] ctrl_val;
   logic [3:0] wsel;
   wdt_mode_t mode;

   // slow oscillator is sampled as a level; each rising edge is one count
   wdt_sync u_osc (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(osc_clk_i),
      .q_o(osc_s)
   );
   wdt_sync u_fuse (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(always_on_fuse_i),
      .q_o(fuse_s)
   );
   wdt_sync u_cause (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(reset_cause_flag_i),
      .q_o(cause_s)
   );
   assign tick = osc_s & ~osc_prev_q; // [RULE15]

   always_comb
   begin
      if (!fuse_s)
         mode = MODE_RST; // [RULE6]
      else
      begin
         case ({rsten_q, irqen_q}) // [RULE5]
            2'b00: mode = MODE_STOP;
            2'b01: mode = MODE_IRQ;
            2'b10: mode = MODE_RST;
            2'b11: mode = MODE_BOTH;
            default: mode = MODE_STOP;
         endcase
      end
   end

   wdt_counter #(
      .CW(CW)
   ) u_cnt (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .run_i(mode != MODE_STOP),
      .tick_i(tick),
      .restart_i(restart_i), // [RULE18]
      .sel_i(sel_q),
      .expire_o(expire)
   );

   assign ctrl_val = {flag_q, irqen_q, sel_q[3], unlock_q, rsten_q, sel_q[2:0]}; // [RULE14]
   assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q
                    & (wb_adr_i == `WDT_ADDR_CTRL) & wb_sel_i[0];
   assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
   assign wv = wb_dat_i[7:0];
   assign wsel = {wv[`WDT_BIT_SEL3], wv[2:0]};

   always_comb
   begin
      flag_d = flag_q;
      irqen_d = irqen_q;
      rsten_d = rsten_q;
      unlock_d = unlock_q;
      ulcnt_d = ulcnt_q;
      sel_d = sel_q;
      rst_d = 1'b0;
      // software writes
      if (wr_ctrl)
      begin
         if (wv[`WDT_BIT_FLAG])
            flag_d = 1'b0; // [RULE3]
         irqen_d = wv[`WDT_BIT_IRQEN];
         if (wv[`WDT_BIT_RSTEN])
            rsten_d = 1'b1;
         else if (unlock_q)
            rsten_d = 1'b0; // [RULE10]
         if (unlock_q)
            sel_d = wsel; // [RULE10]
         if (wv[`WDT_BIT_UNLOCK] && wv[`WDT_BIT_RSTEN])
         begin
            unlock_d = 1'b1;
            ulcnt_d = '0;
         end
         else if (!wv[`WDT_BIT_UNLOCK])
            unlock_d = 1'b0;
      end
      // unlock window closes by itself
      if (unlock_q && !(wr_ctrl && wv[`WDT_BIT_UNLOCK]))
      begin
         ulcnt_d = ulcnt_q + 3'h1;
         if (ulcnt_q + 3'h1 >= `WDT_UNLOCK_CYCLES)
            unlock_d = 1'b0; // [RULE11]
      end
      // vector execution clears the flag; in combined mode also the enable
      if (vector_taken_i && flag_q)
      begin
         flag_d = 1'b0; // [RULE2]
         if (mode == MODE_BOTH)
            irqen_d = 1'b0; // [RULE7]
      end
      // time-out actions: hardware set wins over clears
      if (expire)
      begin
         case (mode)
            MODE_IRQ: flag_d = 1'b1; // [RULE1] [RULE19]
            MODE_BOTH:
            begin
               if (flag_q)
                  rst_d = 1'b1; // [RULE8]
               else
                  flag_d = 1'b1; // [RULE7]
            end
            MODE_RST: rst_d = 1'b1; // [RULE6]
            default: rst_d = 1'b0;
         endcase
      end
      if (cause_s)
         rsten_d = 1'b1; // [RULE12]
      if (!fuse_s)
         irqen_d = 1'b0; // [RULE6]
   end

   always_comb
   begin
      dat_d = 32'h0000_0000;
      if (rd && wb_adr_i == `WDT_ADDR_CTRL)
         dat_d = {24'h00_0000, ctrl_val};
      else if (rd && wb_adr_i == `WDT_ADDR_STAT)
         dat_d = {29'h0000_0000, fuse_s, cause_s, mode == MODE_STOP};
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         flag_q <= 1'b0;
         irqen_q <= 1'b0;
         rsten_q <= 1'b0;
         unlock_q <= 1'b0;
         ulcnt_q <= 3'h0;
         sel_q <= 4'h0;
         rst_q <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         osc_prev_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         irqen_q <= irqen_d;
         rsten_q <= rsten_d;
         unlock_q <= unlock_d;
         ulcnt_q <= ulcnt_d;
         sel_q <= sel_d;
         rst_q <= rst_d;
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         dat_q <= dat_d;
         osc_prev_q <= osc_s;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = flag_q & irqen_q & global_irq_enable_i; // [RULE4]
   assign sys_reset_o = rst_q;
endmodule : watchdog_timer_control

// ---- wdt_cfg.svh ----
// constants for the watchdog control block
// Summary of operation
// (RULE1) time-out in interrupt mode sets timeout_flag
// (RULE2) interrupt vector execution clears timeout_flag
// (RULE3) writing one clears flag, zero keeps
// (RULE4) irq when flag, enable, global enable
// (RULE5) enable bits decode stopped/irq/reset/both modes
// (RULE6) programmed fuse forces reset on every time-out
// (RULE7) vector in combined mode clears enable, flag
// (RULE8) second unserviced time-out in combined mode resets
// (RULE9) software re-arms irq enable outside service routine
// (RULE10) reset_enable clear, select change need unlock
// (RULE11) unlock bit self-clears four cycles later
// (RULE12) reset_cause_flag forces reset_enable to one
// (RULE13) select code gives 2048 doubling to 1048576
// (RULE14) register bit layout and zero reset values
// (RULE15) counter runs on separate slow oscillator
// (RULE16) open change writes unlock and reset_enable together
// (RULE17) new values written within four cycles, unlock clear
// (RULE18) restart instruction restarts counter
// (RULE19) interrupt-mode time-out restarts counter from zero
// (RULE20) reserved select codes act as longest period
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_ADDR_CTRL 4'h0
`define WDT_ADDR_STAT 4'h4
`define WDT_BIT_FLAG 7
`define WDT_BIT_IRQEN 6
`define WDT_BIT_SEL3 5
`define WDT_BIT_UNLOCK 4
`define WDT_BIT_RSTEN 3
`define WDT_UNLOCK_CYCLES 3'h4
`define WDT_SEL_MAX 4'h9
`define WDT_BASE_LOG2 11
`endif

// ---- wdt_pkg.sv ----
// types used by the watchdog control block file
package wdt_pkg;
   typedef enum logic [1:0] {
      MODE_STOP = 2'b00,
      MODE_IRQ = 2'b01,
      MODE_RST = 2'b11,
      MODE_BOTH = 2'b10
   } wdt_mode_t;
endpackage : wdt_pkg

// ---- wdt_sync.sv ----
// two flop synchroniser
`timescale 1ns/1ns
module wdt_sync (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1_q;
   logic s2_q;
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end
      else
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
      end
   end
   assign q_o = s2_q;
endmodule : wdt_sync

// ---- wdt_counter.sv ----
// oscillator-cycle counter with selectable time-out
`timescale 1ns/1ns
`include "wdt_cfg.svh"
module wdt_counter #(
   parameter int CW = 21
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic restart_i,
   input wire logic [3:0] sel_i,
   output logic expire_o
);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] limit;
   logic [3:0] sel_eff;
   logic exp_q;
   logic exp_d;
   always_comb
   begin
      sel_eff = (sel_i > `WDT_SEL_MAX) ? `WDT_SEL_MAX : sel_i; // [RULE20]
      limit = CW'(({{(CW-1){1'b0}}, 1'b1} << (`WDT_BASE_LOG2 + sel_eff)) - 1); // [RULE13]
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!run_i || restart_i)
         cnt_d = '0; // [RULE18]
      else if (tick_i)
      begin
         if (cnt_q >= limit)
         begin
            cnt_d = '0; // [RULE19]
            exp_d = 1'b1;
         end
         else
            cnt_d = cnt_q + CW'(1);
      end
   end
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end
   assign expire_o = exp_q;
endmodule : wdt_counter

// ---- wdt_chk_sva.sv ----
// port-level checker for the watchdog control block
`timescale 1ns/1ns
module wdt_chk (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic reset_cause_flag_i,
   input wire logic global_irq_enable_i,
   input wire logic restart_i,
   input wire logic irq_o,
   input wire logic sys_reset_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic req;
   logic rdq;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rdq = req && !wb_we_i;
   a_ack_next: assert property (req |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (
      rdq && wb_adr_i != 4'h0 && wb_adr_i != 4'h4 |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (rdq |=> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_cause_forces: assert property (
      reset_cause_flag_i [*6] ##0 (rdq && wb_adr_i == 4'h0) |=> wb_dat_o[3])
      else $error("reset enable not forced");
   a_irq_gie: assert property (irq_o |-> global_irq_enable_i)
      else $error("irq without global enable");
   a_rst_pulse: assert property (sys_reset_o |=> !sys_reset_o)
      else $error("reset request not a pulse");
   a_restart_quiet: assert property (restart_i |-> ##6 !sys_reset_o [*8])
      else $error("reset right after restart");
   c_reset: cover property (sys_reset_o);
   c_irq: cover property (irq_o);
   c_cause_read: cover property (reset_cause_flag_i && wb_ack_o);
endmodule : wdt_chk
bind watchdog_timer_control wdt_chk i_wdt_chk (.core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .reset_cause_flag_i, .global_irq_enable_i,
   .restart_i, .irq_o, .sys_reset_o);

// ---- tb.sv ----
// self-checking bench for the watchdog control block
`timescale 1ns/1ns
module tb;
   logic core_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, osc_clk_i;
   logic always_on_fuse_i, reset_cause_flag_i, global_irq_enable_i;
   logic vector_taken_i, restart_i, irq_o, sys_reset_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   int n_fail = 0, checks_done = 0, cyc_n = 0, n;
   // rows: address, write byte, expected control read
   logic [19:0] tbl [5] = '{20'h0_4040, 20'h0_4848, 20'h0_4048, 20'h0_4D48, 20'h8_FF48};
   watchdog_timer_control i_watchdog_timer_control (.core_clk_i, .nrst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .osc_clk_i, .always_on_fuse_i, .reset_cause_flag_i, .global_irq_enable_i,
      .vector_taken_i, .restart_i, .irq_o, .sys_reset_o);
   initial
   begin
      core_clk_i = 0;
      forever #20 core_clk_i = ~core_clk_i;
   end
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   // fast oscillator stand-in, one rising edge every two core cycles
   always @(posedge core_clk_i)
   begin
      osc_clk_i <= ~osc_clk_i;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 90000)
      begin
         n_fail++;
         summarize();
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task xf(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      // ack and read data are taken at the edge where ack is sampled high
      do
         @(posedge core_clk_i);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask : xf
   task rc(input logic [7:0] e);
      xf(0, 4'h0, 8'h00);
      chk(rd[7:0], e);
   endtask : rc
   task wt(input logic r, input logic hit);
      n = 0;
      while ((r ? sys_reset_o : irq_o) !== 1'b1 && n < 6000)
      begin
         @(negedge core_clk_i);
         n++;
      end
      chk(8'(n < 6000), 8'(hit));
   endtask : wt
   task pulse(input logic v);
      if (v)
         vector_taken_i <= 1;
      else
         restart_i <= 1;
      @(posedge core_clk_i);
      vector_taken_i <= 0;
      restart_i <= 0;
   endtask : pulse
   initial
   begin
      {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, osc_clk_i, reset_cause_flag_i} = 0;
      {vector_taken_i, restart_i, wb_adr_i, wb_dat_i} = 0;
      {always_on_fuse_i, global_irq_enable_i, wb_sel_i} = 6'h3F;
      repeat (5) @(posedge core_clk_i);
      nrst_i <= 1;
      rc(8'h00);
      foreach (tbl[i])
      begin
         xf(1, tbl[i][19:16], tbl[i][15:8]);
         rc(tbl[i][7:0]);
      end
      xf(0, 4'h8, 8'h00);
      chk(rd[7:0], 8'h00);
      xf(1, 4'h0, 8'h18);
      xf(1, 4'h0, 8'h01);
      rc(8'h01);
      xf(1, 4'h0, 8'h18);
      repeat (6) @(posedge core_clk_i);
      rc(8'h09);
      $display("register test done");
      xf(1, 4'h0, 8'h18);
      xf(1, 4'h0, 8'h40);
      pulse(0);
      wt(0, 1);
      chk(8'(n >= 4090 && n <= 4112), 8'h01);
      rc(8'hC0);
      global_irq_enable_i <= 0;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(8'(irq_o), 8'h00);
      global_irq_enable_i <= 1;
      xf(1, 4'h0, 8'h40);
      rc(8'hC0);
      xf(1, 4'h0, 8'hC0);
      rc(8'h40);
      wt(0, 1);
      pulse(1);
      rc(8'h40);
      $display("interrupt mode test done");
      xf(1, 4'h0, 8'h48);
      pulse(0);
      wt(0, 1);
      rc(8'hC8);
      wt(1, 1);
      xf(1, 4'h0, 8'hC8);
      wt(0, 1);
      pulse(1);
      rc(8'h08);
      xf(1, 4'h0, 8'h48);
      rc(8'h48);
      $display("combined mode test done");
      xf(1, 4'h0, 8'h18);
      xf(1, 4'h0, 8'h00);
      wt(1, 0);
      xf(0, 4'h4, 8'h00);
      chk(rd[7:0], 8'h05);
      always_on_fuse_i <= 0;
      wt(1, 1);
      always_on_fuse_i <= 1;
      reset_cause_flag_i <= 1;
      repeat (6) @(posedge core_clk_i);
      xf(1, 4'h0, 8'h18);
      xf(1, 4'h0, 8'h00);
      rc(8'h08);
      xf(0, 4'h4, 8'h00);
      chk(rd[7:0], 8'h06);
      $display("fuse and cause test done");
      summarize();
   end
endmodule : tb
